/* File: hdl/rsa_pkg.sv */
/*
  Shared constants, types and the register map of the remote station
  number assignment block.
  Assumes a single 40 MHz system clock and an APB master with 32-bit data.
*/
package rsa_pkg;

  // ----------------------------------------------------------------------
  // Clock and link slot timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS      = 25;
  localparam int SLOT4_NS    = 1000;  // Per-station link slot, 4-point mode
  localparam int SLOT16_NS   = 2000;  // Per-station link slot, 16-point mode
  localparam logic [7:0] SLOT4_CYC  = 8'((SLOT4_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SLOT16_CYC = 8'((SLOT16_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------------
  // Station table
  // ----------------------------------------------------------------------
  localparam logic [5:0]  STN_LAST    = 6'h3f;   // 64 station numbers
  localparam logic [12:0] STN_LIMIT   = 13'h0040;
  localparam logic [6:0]  BMW_FIRST   = 7'h20;   // Buffer memory word 32
  localparam logic [6:0]  BMW_LAST    = 7'h5f;   // Buffer memory word 95
  localparam logic [7:0]  XBASE_RST   = 8'h20;   // First remote input, octal 040
  localparam logic [7:0]  YBASE_RST   = 8'h10;   // First remote output, octal 020

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_ISTAT   = 12'h008;
  localparam logic [11:0] OFS_IMASK   = 12'h00c;
  localparam logic [11:0] OFS_BASE    = 12'h010;
  localparam logic [11:0] OFS_SEL     = 12'h014;
  localparam logic [11:0] OFS_ASSIGN  = 12'h018;

  // Interrupt status bit positions
  localparam int IRQ_SCAN   = 0;
  localparam int IRQ_CFGERR = 1;
  localparam int IRQ_FAULT  = 2;
  localparam int IRQ_ASSIGN = 3;

  // Station detail word
  typedef struct packed {
    logic       reserved;     // Bit 15: reserved station
    logic       remote_dev;   // Bit 14: remote device station
    logic       out_hold;     // 1 = hold outputs, 0 = clear
    logic       in_filter;    // 1 = special filter, 0 = general input
    logic       head;         // First station number of a unit
    logic       spare;
    logic       out_present;
    logic       in_present;
    logic [7:0] points;
  } rsa_detail_s;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h0,
    ST_NVLD = 4'h1,
    ST_NVWT = 4'h2,
    ST_POLL = 4'h3,
    ST_PWAIT = 4'h4,
    ST_GAP  = 4'h5,
    ST_RUN  = 4'h6,
    ST_ASGN = 4'h7,
    ST_HALT = 4'h8
  } rsa_state_e;

endpackage : rsa_pkg

/* File: hdl/rsa_assign.sv */
/*
  Station occupancy and input/output number assignment of a field-network
  master: setup scan, nonvolatile store/load, numbering walk, online polling
  with station fault detection, APB registers and one interrupt.
  Assumes an APB master, a link engine answering poll requests with one
  poll_ack pulse, and a nonvolatile store answering reads with nvm_rvalid.

*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps

module rsa_assign (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                mode_sw6,
  input  wire logic                mode_sw7,
  output logic                     poll_req,
  output logic [5:0]               poll_stn,
  input  wire logic                poll_ack,
  input  wire logic                poll_present,
  input  wire rsa_pkg::rsa_detail_s poll_info,
  output logic                     nvm_we,
  output logic                     nvm_re,
  output logic [5:0]               nvm_addr,
  output rsa_pkg::rsa_detail_s     nvm_wdata,
  input  wire logic                nvm_rvalid,
  input  wire rsa_pkg::rsa_detail_s nvm_rdata,
  output logic                     remote_io_en,
  output logic                     local_io_en,
  output logic                     irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rsa_pkg::rsa_state_e  state, next_state;
  rsa_pkg::rsa_detail_s detail [64];
  logic [7:0]  xs [64];
  logic [7:0]  ys [64];
  logic [5:0]  idx, next_idx, fault_stn, next_fault_stn, next_poll_stn, next_nvm_addr;
  logic [7:0]  gap, next_gap, xc, next_xc, yc, next_yc;
  logic [12:0] occ, next_occ;
  logic        setup, next_setup, cfg_err, next_cfg_err, reassign, next_reassign;
  logic        next_poll_req, next_nvm_re, go_asgn, busy;
  logic [3:0]  ev;
  logic        tbl_we, tbl_from_nvm;
  logic [5:0]  tbl_idx;
  rsa_pkg::rsa_detail_s tbl_data, cur;
  // Register file state
  logic        mode16, next_mode16;
  logic [7:0]  x_base, next_x_base, y_base, next_y_base;
  logic [5:0]  sel, next_sel;
  logic [3:0]  istat, next_istat, imask, next_imask;
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic        wr, rescan, edit_evt, ed_we;
  logic        in_bmw;
  logic [6:0]  bmw_word;
  logic [5:0]  ed_idx;

  // Per-direction point counts of a detail word
  function automatic logic [7:0] in_pts(input rsa_pkg::rsa_detail_s d);
    in_pts = !d.in_present ? 8'h00 : (d.out_present ? {1'b0, d.points[7:1]} : d.points);
  endfunction : in_pts

  function automatic logic [7:0] out_pts(input rsa_pkg::rsa_detail_s d);
    out_pts = !d.out_present ? 8'h00 : (d.in_present ? {1'b0, d.points[7:1]} : d.points);
  endfunction : out_pts

  assign cur = detail[idx];

  // Table is owned by the sequencer while it loads, scans or walks
  assign busy = (state == rsa_pkg::ST_BOOT) || (state == rsa_pkg::ST_NVLD)
             || (state == rsa_pkg::ST_NVWT) || (state == rsa_pkg::ST_ASGN)
             || (setup && ((state == rsa_pkg::ST_POLL) || (state == rsa_pkg::ST_PWAIT)));

  // ----------------------------------------------------------------------
  // Sequencer: boot, scan, load, walk, online polling
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_idx       = idx;
    next_gap       = gap;
    next_xc        = xc;
    next_yc        = yc;
    next_occ       = occ;
    next_setup     = setup;
    next_cfg_err   = cfg_err;
    next_fault_stn = fault_stn;
    next_reassign  = reassign | edit_evt;
    next_poll_req  = 1'b0;
    next_poll_stn  = poll_stn;
    next_nvm_re    = 1'b0;
    next_nvm_addr  = nvm_addr;
    go_asgn        = 1'b0;
    ev             = 4'h0;
    tbl_we         = 1'b0;
    tbl_from_nvm   = 1'b0;
    tbl_idx        = idx;
    tbl_data       = poll_info;
    unique case (state)
      rsa_pkg::ST_BOOT:
      begin
        next_setup = mode_sw6 & ~mode_sw7;
        next_idx   = 6'h00;
        next_state = (mode_sw6 & ~mode_sw7) ? rsa_pkg::ST_POLL : rsa_pkg::ST_NVLD;
      end
      rsa_pkg::ST_NVLD:
      begin
        next_nvm_re   = 1'b1;
        next_nvm_addr = idx;
        next_state    = rsa_pkg::ST_NVWT;
      end
      rsa_pkg::ST_NVWT:
      begin
        next_nvm_re = ~nvm_rvalid;
        if (nvm_rvalid)
        begin
          tbl_we       = 1'b1;
          tbl_from_nvm = 1'b1;
          tbl_data     = nvm_rdata;
          next_idx     = idx + 6'h01;
          if (idx == rsa_pkg::STN_LAST)
            go_asgn = 1'b1;
          else
            next_state = rsa_pkg::ST_NVLD;
        end
      end
      rsa_pkg::ST_POLL:
      begin
        next_poll_req = 1'b1;
        next_poll_stn = idx;
        next_state    = rsa_pkg::ST_PWAIT;
      end
      rsa_pkg::ST_PWAIT:
      begin
        next_poll_req = ~poll_ack;
        if (poll_ack && setup)
        begin
          // scan in station order, keep the result
          tbl_we   = 1'b1;
          tbl_data = poll_present ? poll_info : '0;
          next_idx = idx + 6'h01;
          if (idx == rsa_pkg::STN_LAST)
          begin
            ev[rsa_pkg::IRQ_SCAN] = 1'b1;
            go_asgn = 1'b1;
          end
          else
            next_state = rsa_pkg::ST_POLL;
        end
        else if (poll_ack)
        begin
          // silent station faults only when not reserved
          if (!poll_present && !cur.reserved)
          begin
            ev[rsa_pkg::IRQ_FAULT] = 1'b1;
            next_fault_stn = idx;
          end
          // slot length depends on point mode
          next_gap   = mode16 ? rsa_pkg::SLOT16_CYC : rsa_pkg::SLOT4_CYC;
          next_state = rsa_pkg::ST_GAP;
        end
      end
      rsa_pkg::ST_GAP:
      begin
        next_gap = gap - 8'h01;
        if (gap == 8'h01)
        begin
          next_idx   = idx + 6'h01;
          next_state = rsa_pkg::ST_RUN;
        end
      end
      rsa_pkg::ST_RUN:
      begin
        if (reassign)
          go_asgn = 1'b1;
        else if (cur.head)
          next_state = rsa_pkg::ST_POLL;
        else
          next_idx = idx + 6'h01;
      end
      rsa_pkg::ST_ASGN:
      begin
        if (cur.head && !cur.remote_dev)
        begin
          next_xc = xc + in_pts(cur);
          next_yc = yc + out_pts(cur);
          next_occ = occ + (mode16 ? 13'h0001 :
                     13'((({1'b0, cur.points} + 9'h003) >> 2) | {8'h00, cur.points == 8'h00}));
        end
        next_idx = idx + 6'h01;
        if (idx == rsa_pkg::STN_LAST)
        begin
          // reject more than 64 occupied stations
          next_cfg_err = next_occ > rsa_pkg::STN_LIMIT;
          ev[rsa_pkg::IRQ_CFGERR] = next_occ > rsa_pkg::STN_LIMIT;
          ev[rsa_pkg::IRQ_ASSIGN] = 1'b1;
          next_state = setup ? rsa_pkg::ST_HALT : rsa_pkg::ST_RUN;
        end
      end
      rsa_pkg::ST_HALT:
      begin
        if (rescan)
        begin
          next_idx   = 6'h00;
          next_state = rsa_pkg::ST_POLL;
        end
        else if (reassign)
          go_asgn = 1'b1;
      end
      default:
        next_state = rsa_pkg::ST_BOOT;
    endcase
    // walk restarts from the first remote numbers in x_base and y_base
    if (go_asgn)
    begin
      next_state    = rsa_pkg::ST_ASGN;
      next_idx      = 6'h00;
      next_xc       = x_base;
      next_yc       = y_base;
      next_occ      = 13'h0000;
      next_reassign = edit_evt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= rsa_pkg::ST_BOOT;
      idx          <= 6'h00;
      gap          <= 8'h00;
      xc           <= 8'h00;
      yc           <= 8'h00;
      occ          <= 13'h0000;
      setup        <= 1'b0;
      cfg_err      <= 1'b0;
      fault_stn    <= 6'h00;
      reassign     <= 1'b0;
      poll_req     <= 1'b0;
      poll_stn     <= 6'h00;
      nvm_re       <= 1'b0;
      nvm_addr     <= 6'h00;
      remote_io_en <= 1'b0;
      local_io_en  <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      idx          <= next_idx;
      gap          <= next_gap;
      xc           <= next_xc;
      yc           <= next_yc;
      occ          <= next_occ;
      setup        <= next_setup;
      cfg_err      <= next_cfg_err;
      fault_stn    <= next_fault_stn;
      reassign     <= next_reassign;
      poll_req     <= next_poll_req;
      poll_stn     <= next_poll_stn;
      nvm_re       <= next_nvm_re;
      nvm_addr     <= next_nvm_addr;
      // remote points live only online with a valid assignment
      remote_io_en <= ~next_setup & ~next_cfg_err & ((next_state == rsa_pkg::ST_RUN)
                   || (next_state == rsa_pkg::ST_POLL) || (next_state == rsa_pkg::ST_PWAIT)
                   || (next_state == rsa_pkg::ST_GAP));
      // local extensions also held off in setup mode
      local_io_en  <= ~next_setup & (next_state != rsa_pkg::ST_BOOT);
    end
  end

  // ----------------------------------------------------------------------
  // Station table, number table and nonvolatile write port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 64; i++)
      begin
        detail[i] <= '0;
        xs[i]     <= 8'h00;
        ys[i]     <= 8'h00;
      end
      nvm_we    <= 1'b0;
      nvm_wdata <= '0;
    end
    else
    begin
      if (tbl_we)
        detail[tbl_idx] <= tbl_data;
      else if (ed_we)
        detail[ed_idx] <= rsa_pkg::rsa_detail_s'(pwdata[15:0]);
      if (state == rsa_pkg::ST_ASGN)
      begin
        xs[idx] <= xc;
        ys[idx] <= yc;
      end
      nvm_we    <= (tbl_we & ~tbl_from_nvm) | ed_we;
      nvm_wdata <= tbl_we ? tbl_data : rsa_pkg::rsa_detail_s'(pwdata[15:0]);
    end
  end

  // ----------------------------------------------------------------------
  // APB slave, one wait state so read data leaves a flip-flop
  // ----------------------------------------------------------------------
  assign wr       = psel & penable & pready & pwrite;
  assign bmw_word = paddr[8:2];
  assign in_bmw   = (paddr[1:0] == 2'b00) && (paddr[11:9] == 3'b000)
                 && (bmw_word >= rsa_pkg::BMW_FIRST) && (bmw_word <= rsa_pkg::BMW_LAST);
  assign ed_idx   = 6'(bmw_word - rsa_pkg::BMW_FIRST);
  // Edits are dropped while the sequencer owns the table
  assign ed_we    = wr & in_bmw & ~busy;
  assign rescan   = wr & (paddr == rsa_pkg::OFS_CTRL) & pwdata[1] & setup;
  assign edit_evt = ed_we | (wr & ((paddr == rsa_pkg::OFS_BASE)
                 || ((paddr == rsa_pkg::OFS_CTRL) && (pwdata[0] != mode16))));

  always_comb
  begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    next_mode16  = mode16;
    next_x_base  = x_base;
    next_y_base  = y_base;
    next_sel     = sel;
    next_imask   = imask;
    // Hardware set wins over a write-one clear in the same cycle
    next_istat   = (istat & ~((wr && paddr == rsa_pkg::OFS_ISTAT) ? pwdata[3:0] : 4'h0)) | ev;
    if (psel & penable & ~pready)
    begin
      if (in_bmw)
        next_prdata = {16'h0000, detail[ed_idx]};
      else
      begin
        unique case (paddr)
          rsa_pkg::OFS_CTRL:   next_prdata = {31'h0, mode16};
          rsa_pkg::OFS_STATUS: next_prdata = {18'h0, fault_stn, 4'h0, busy, remote_io_en,
                                              cfg_err, setup};
          rsa_pkg::OFS_ISTAT:  next_prdata = {28'h0, istat};
          rsa_pkg::OFS_IMASK:  next_prdata = {28'h0, imask};
          rsa_pkg::OFS_BASE:   next_prdata = {16'h0, y_base, x_base};
          rsa_pkg::OFS_SEL:    next_prdata = {26'h0, sel};
          rsa_pkg::OFS_ASSIGN: next_prdata = {16'h0, ys[sel], xs[sel]};
          default:             next_pslverr = 1'b1;
        endcase
      end
    end
    if (wr)
    begin
      unique case (paddr)
        rsa_pkg::OFS_CTRL:  next_mode16 = pwdata[0];
        rsa_pkg::OFS_IMASK: next_imask  = pwdata[3:0];
        rsa_pkg::OFS_SEL:   next_sel    = pwdata[5:0];
        rsa_pkg::OFS_BASE:
        begin
          next_x_base = pwdata[7:0];
          next_y_base = pwdata[15:8];
        end
        default:            next_sel    = sel;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      mode16  <= 1'b0;
      x_base  <= rsa_pkg::XBASE_RST;
      y_base  <= rsa_pkg::YBASE_RST;
      sel     <= 6'h00;
      istat   <= 4'h0;
      imask   <= 4'h0;
      irq     <= 1'b0;
    end
    else
    begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
      mode16  <= next_mode16;
      x_base  <= next_x_base;
      y_base  <= next_y_base;
      sel     <= next_sel;
      istat   <= next_istat;
      imask   <= next_imask;
      irq     <= |(next_istat & next_imask);
    end
  end

endmodule : rsa_assign

/* File: tb/rsa_assign_assertions.sv */
/*
  Port checker for rsa_assign: APB timing, poll and store handshakes.
  Assumes the mode switches only change while rst_n is low.
*/
`timescale 1ns/10ps
module rsa_assign_assertions (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       mode_sw6,
  input wire logic       mode_sw7,
  input wire logic       poll_req,
  input wire logic [5:0] poll_stn,
  input wire logic       poll_ack,
  input wire logic       nvm_re,
  input wire logic       nvm_rvalid,
  input wire logic       nvm_we,
  input wire logic       remote_io_en,
  input wire logic       local_io_en
);
  // ------------------------------------------------------------
  // Shared terms
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire setup = mode_sw6 & ~mode_sw7;
  sequence poll_done;
    poll_req && poll_ack;
  endsequence
  sequence next_poll;
    !poll_req ##1 (poll_req && poll_stn == $past(poll_stn, 2) + 6'h01);
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  apb_wait_a : assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing in second access cycle");
  apb_pulse_a : assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  setup_remote_a : assert property (setup |-> !remote_io_en)
    else $error("remote io active in setup");
  setup_local_a : assert property (setup |-> !local_io_en)
    else $error("local io active in setup");
  poll_hold_a : assert property (poll_req && !poll_ack |=> poll_req && $stable(poll_stn))
    else $error("poll request dropped early");
  poll_drop_a : assert property (poll_done |=> !poll_req)
    else $error("poll request kept after answer");
  nvm_drop_a : assert property (nvm_re && nvm_rvalid |=> !nvm_re)
    else $error("store read kept after answer");
  scan_order_a : assert property ((setup && poll_stn != 6'h3f) and poll_done |=> next_poll)
    else $error("setup scan not in station order");
  scan_store_a : assert property (setup and poll_done |-> ##[1:4] nvm_we)
    else $error("scan result not stored");
endmodule : rsa_assign_assertions

bind rsa_assign rsa_assign_assertions rsa_assign_assertions_inst (
  .clk_sys, .rst_n, .psel, .penable, .pready, .mode_sw6, .mode_sw7,
  .poll_req, .poll_stn, .poll_ack, .nvm_re, .nvm_rvalid, .nvm_we,
  .remote_io_en, .local_io_en
);

/* File: tb/rsa_station_model.sv */
/*
  Far side of rsa_assign: five link stations and the nonvolatile store.
  Assumes one poll and one store read outstanding at a time.
*/
`timescale 1ns/10ps
module rsa_station_model (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 poll_req,
  input  wire logic [5:0]           poll_stn,
  input  wire logic [6:0]           drop_stn,
  output rsa_pkg::rsa_detail_s      poll_info,
  output logic                      poll_ack,
  output logic                      poll_present,
  input  wire logic                 nvm_we,
  input  wire logic                 nvm_re,
  input  wire logic [5:0]           nvm_addr,
  input  wire rsa_pkg::rsa_detail_s nvm_wdata,
  output logic                      nvm_rvalid,
  output rsa_pkg::rsa_detail_s      nvm_rdata
);
  logic [15:0] mem [64];
  logic [6:0]  wr_idx = 7'h00;
  logic [1:0]  dly;

  function automatic logic [15:0] stn_word(input logic [5:0] s);
    case (s)
      6'h00, 6'h04: stn_word = 16'h0904;
      6'h01, 6'h03: stn_word = 16'h0b04;
      6'h02:        stn_word = 16'h0910;
      default:      stn_word = 16'h0000;
    endcase
  endfunction : stn_word

  // Store keeps the first 64 writes; it survives reset like real memory
  always @(posedge clk_sys)
  begin
    if (nvm_we && !wr_idx[6])
    begin
      mem[wr_idx[5:0]] <= nvm_wdata;
      wr_idx           <= wr_idx + 7'h01;
    end
  end

  // Answers: odd stations answer slowly; idle lines show inverted values
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      poll_ack   <= 1'h0;
      nvm_rvalid <= 1'h0;
      dly        <= 2'h0;
    end
    else
    begin
      poll_ack     <= 1'h0;
      nvm_rvalid   <= 1'h0;
      poll_info    <= ~poll_info;
      poll_present <= ~poll_present;
      nvm_rdata    <= ~nvm_rdata;
      if (poll_req && !poll_ack)
      begin
        dly <= dly + 2'h1;
        if (dly == {poll_stn[0], 1'h0})
        begin
          dly          <= 2'h0;
          poll_ack     <= 1'h1;
          poll_present <= stn_word(poll_stn) != 16'h0 && {1'h0, poll_stn} != drop_stn;
          poll_info    <= stn_word(poll_stn);
        end
      end
      if (nvm_re && !nvm_rvalid)
      begin
        nvm_rvalid <= 1'h1;
        nvm_rdata  <= mem[nvm_addr];
      end
    end
  end
endmodule : rsa_station_model

/* File: tb/rsa_assign_tb.sv */
/*
  Testbench for rsa_assign: setup scan, edits, rescan, interrupt, then an
  online boot from the stored words with one silent station.
  Assumes the station model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module rsa_assign_tb;
  logic                 clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic                 mode_sw6, mode_sw7, poll_req, poll_ack, poll_present, irq;
  logic                 nvm_we, nvm_re, nvm_rvalid, remote_io_en, local_io_en;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rdat;
  logic [5:0]           poll_stn, nvm_addr;
  logic [6:0]           drop_stn;
  rsa_pkg::rsa_detail_s poll_info, nvm_wdata, nvm_rdata;
  int                   err_total, tests_run, cyc, s4, s16;
  logic [15:0]          exp_a [6] = '{16'h0020, 16'h1024, 16'h0026, 16'h1236, 16'h0038,
                                      16'h003c};
  logic [15:0]          msk_a [6] = '{16'h00ff, 16'hffff, 16'h00ff, 16'hffff, 16'h00ff,
                                      16'h00ff};

  rsa_assign rsa_assign_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .mode_sw6, .mode_sw7, .poll_req, .poll_stn, .poll_ack,
    .poll_present, .poll_info, .nvm_we, .nvm_re, .nvm_addr, .nvm_wdata, .nvm_rvalid,
    .nvm_rdata, .remote_io_en, .local_io_en, .irq);
  rsa_station_model rsa_station_model_inst (.clk_sys, .rst_n, .poll_req, .poll_stn,
    .drop_stn, .poll_info, .poll_ack, .poll_present, .nvm_we, .nvm_re, .nvm_addr,
    .nvm_wdata, .nvm_rvalid, .nvm_rdata);

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, m, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask : rdc

  task automatic wait_set(input logic [11:0] a, input logic [31:0] m);
    do apb(1'h0, a, 32'h0); while ((rdat & m) !== m);
  endtask : wait_set

  task automatic check_assign(input int n);
    for (int i = 0; i < n; i++)
    begin
      apb(1'h1, rsa_pkg::OFS_SEL, 32'(i));
      rdc(rsa_pkg::OFS_ASSIGN, {16'h0, exp_a[i]}, {16'h0, msk_a[i]}, "assign");
    end
  endtask : check_assign

  // Cycles from the answer of station 0 to the poll of station 1
  task automatic poll_span(output int n);
    n = 0;
    do @(posedge clk_sys); while (poll_ack !== 1'h1 || poll_stn !== 6'h00);
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (poll_req !== 1'h1 || poll_stn !== 6'h01);
  endtask : poll_span

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk_sys  = 1'h0;
    rst_n    = 1'h0;
    psel     = 1'h0;
    penable  = 1'h0;
    pwrite   = 1'h0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    drop_stn = 7'h40;
    mode_sw6 = 1'h1;
    mode_sw7 = 1'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    rdc(rsa_pkg::OFS_BASE, 32'h1020, 32'hffff, "base");
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    wait_set(rsa_pkg::OFS_ISTAT, 32'h1);
    rdc(rsa_pkg::OFS_STATUS, 32'h1, 32'h5, "status");
    chk("local_io_en", 32'h0, {31'h0, local_io_en});
    rdc(12'h080, 32'h0904, 32'hffffffff, "word0");
    rdc(12'h088, 32'h0910, 32'hffffffff, "word2");
    check_assign(5);
    // Interrupt: masked, unmasked, cleared
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h1, rsa_pkg::OFS_IMASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'hf);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    // Edit of an empty station keeps the others
    apb(1'h1, 12'h094, 32'h8904);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h8);
    check_assign(6);
    // A 255-point unit breaks the 4-point limit; 16-point mode takes it
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'h8);
    apb(1'h1, 12'h094, 32'h08ff);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h8);
    rdc(rsa_pkg::OFS_STATUS, 32'h2, 32'h2, "cfg_err");
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'h8);
    apb(1'h1, rsa_pkg::OFS_CTRL, 32'h1);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h8);
    rdc(rsa_pkg::OFS_STATUS, 32'h0, 32'h2, "cfg_err");
    apb(1'h1, rsa_pkg::OFS_CTRL, 32'h2);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h1);
    rdc(12'h094, 32'h0, 32'hffffffff, "word5");
    // Online boot from the store, station 3 silent
    rst_n    <= 1'h0;
    mode_sw6 <= 1'h0;
    drop_stn <= 7'h03;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    wait_set(rsa_pkg::OFS_STATUS, 32'h4);
    chk("local_io_en", 32'h1, {31'h0, local_io_en});
    check_assign(5);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h4);
    rdc(rsa_pkg::OFS_STATUS, 32'h0300, 32'h3f00, "fault_stn");
    apb(1'h1, 12'h08c, 32'h8b04);
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'h4);
    repeat (600) @(posedge clk_sys);
    rdc(rsa_pkg::OFS_ISTAT, 32'h0, 32'h4, "fault");
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'h8);
    apb(1'h1, rsa_pkg::OFS_BASE, 32'h1430);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h8);
    apb(1'h1, rsa_pkg::OFS_SEL, 32'h1);
    rdc(rsa_pkg::OFS_ASSIGN, 32'h1434, 32'hffff, "moved");
    // Same stations, longer slot once 16-point mode is walked in
    poll_span(s4);
    apb(1'h1, rsa_pkg::OFS_ISTAT, 32'h8);
    apb(1'h1, rsa_pkg::OFS_CTRL, 32'h1);
    wait_set(rsa_pkg::OFS_ISTAT, 32'h8);
    poll_span(s16);
    chk("slot", 32'(rsa_pkg::SLOT16_CYC - rsa_pkg::SLOT4_CYC), 32'(s16 - s4));
    finish_test();
  end
endmodule : rsa_assign_tb
